/* ees_bm.sv */
// two-wire bus master model; clock stands high between frames
`default_nettype none
module ees_bm (
	// clock
	input wire logic clk,
	// bus
	output logic scl,
	output logic sda_oe,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus: both lines released
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one bit: data moves in low phase, sampled mid high
	task automatic bit_x(input logic b, output logic r);
		wt(2);
		sda_oe <= ~b;
		wt(2);
		scl <= 1'b1;
		wt(2);
		r = sda;
		wt(2);
		scl <= 1'b0;
	endtask
	// also used as repeated start
	task automatic start_c();
		wt(2);
		sda_oe <= 1'b0;
		wt(2);
		scl <= 1'b1;
		wt(4);
		sda_oe <= 1'b1;
		wt(4);
		scl <= 1'b0;
	endtask
	task automatic stop_c();
		wt(2);
		sda_oe <= 1'b1;
		wt(2);
		scl <= 1'b1;
		wt(4);
		sda_oe <= 1'b0;
		wt(8);
	endtask
	task automatic tx(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(b[i], r);
		bit_x(1'b1, ack);
	endtask
	task automatic rx(input logic nack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
		bit_x(nack, r);
	endtask
endmodule
`default_nettype wire

/* ees_map.svh */
// constants of the serial eeprom bus slave: field positions, sizes, timing
`ifndef EES_MAP_SVH
`define EES_MAP_SVH

// ----------------------------------------------------------------------
// control byte layout
// ----------------------------------------------------------------------
`define EES_CB_TYPE_MSB 7
`define EES_CB_TYPE_LSB 4
`define EES_CB_CS_MSB 3
`define EES_CB_CS_LSB 1
`define EES_CB_RW 0
`define EES_RW_READ 1'b1

// ----------------------------------------------------------------------
// word address, page buffer and bit counter
// ----------------------------------------------------------------------
`define EES_ADDR_W 15
`define EES_PAGE_AW 6
`define EES_PAGE_BYTES 64
`define EES_CNT_W 7
`define EES_BITS_PER_BYTE 4'h8
`define EES_ACK_SLOT 4'h9

// ----------------------------------------------------------------------
// write cycle timing
// ----------------------------------------------------------------------
`define EES_TWC_MS 5
`define EES_CLK_KHZ 25000
`define EES_TWC_CYC (`EES_TWC_MS * `EES_CLK_KHZ)
`define EES_TMR_W 17

// ----------------------------------------------------------------------
// reset values and default type code
// ----------------------------------------------------------------------
`define EES_ADDR_RST 15'h0000
`define EES_TYPE_DEFAULT 4'h5

`endif

/* ees_page_buf.sv */
// page buffer memory: one write port, registered read port
`default_nettype none
`include "ees_map.svh"

module ees_page_buf
	import ees_pkg::*;
#(
	parameter int unsigned AW = `EES_PAGE_AW,
	parameter int unsigned DEPTH = `EES_PAGE_BYTES
) (
	// clock
	input wire logic clk,
	// write side
	input var ees_bufwr_t wr,
	// read side
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);

	logic [7:0] mem [DEPTH];

	// plain array, no reset needed; read data comes from a register
	always_ff @(posedge clk) begin
		if (wr.we) begin
			mem[wr.addr] <= wr.data;
		end
		rdata <= mem[raddr];
	end

endmodule

`default_nettype wire

/* ees_pkg.sv */
// types shared by the serial eeprom bus slave modules
`default_nettype none
`include "ees_map.svh"

package ees_pkg;

	// synchronised pin group
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] cs;
	} ees_pins_t;

	// synchroniser state: two stages
	typedef struct packed {
		ees_pins_t s1;
		ees_pins_t s2;
	} ees_sync_t;

	// protocol phase
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CTRL,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} ees_st_t;

	// page buffer write request
	typedef struct packed {
		logic we;
		logic [`EES_PAGE_AW-1:0] addr;
		logic [7:0] data;
	} ees_bufwr_t;

	// slave state, less synchroniser and page buffer
	typedef struct packed {
		ees_st_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic sda_oe;
		logic scl_q;
		logic sda_q;
		logic [`EES_ADDR_W-1:0] addr;
		logic [`EES_ADDR_W-1:0] base;
		logic [`EES_CNT_W-1:0] cnt;
		logic busy;
		logic [`EES_TMR_W-1:0] tmr;
		logic wr_start;
		logic blocked;
		ees_bufwr_t bw;
	} ees_state_t;

endpackage

`default_nettype wire

/* ees_slave.sv */
// two-wire bus slave front end of a serial eeprom
//
// Contract
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - driven sda changes only while scl low
// - one bit per scl pulse, sampled high
// - receiver acknowledges each received byte
// - no acknowledge during internal programming
// - ack holds sda low through high phase
// - master nack ends read, slave releases
// - control byte top nibble is type code
// - chip-select bits must match strap pins
// - full match acknowledges, then picks direction
// - last control bit: one read, zero write
// - two address bytes, high first, 15 bits
// - only last 64 bytes kept, overwrite
// - write protect blocks writes, reads unaffected
// - write protect sampled at the stop
// - write cycle completes within 5 ms
`default_nettype none
`include "ees_map.svh"

module ees_slave
	import ees_pkg::*;
#(
	// type code value is arbitrary
	parameter logic [3:0] DEV_TYPE = `EES_TYPE_DEFAULT,
	// write cycle length in clk cycles
	parameter int unsigned TWC_CYC = `EES_TWC_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// two-wire bus pins
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// strap and protect pins
	input wire logic chip_sel_bit0,
	input wire logic chip_sel_bit1,
	input wire logic chip_sel_bit2,
	input wire logic write_protect_in,
	// array read side
	output logic [`EES_ADDR_W-1:0] rd_addr,
	input wire logic [7:0] rd_data,
	// array write side
	output logic wr_start,
	output logic [`EES_ADDR_W-1:0] wr_addr,
	output logic [`EES_CNT_W-1:0] wr_count,
	output logic wr_busy,
	output logic wr_blocked,
	input wire logic [`EES_PAGE_AW-1:0] buf_raddr,
	output logic [7:0] buf_rdata
);

	// ------------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------------

	ees_pins_t pins_raw;
	ees_pins_t pins;

	// straps and protect pass the same two stages as the bus, so a
	// strap moved after reset has settled before it is compared
	// gather the asynchronous pins into one group
	always_comb begin
		pins_raw.scl = scl_i;
		pins_raw.sda = sda_i;
		pins_raw.wp = write_protect_in;
		pins_raw.cs = {chip_sel_bit2, chip_sel_bit1, chip_sel_bit0};
	end

	ees_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pins_in(pins_raw),
		.pins_out(pins)
	);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------

	// one packed record holds every flop of the slave except the
	// synchroniser and page buffer ones; q_nxt is the whole of it
	// as it will stand after the coming edge
	ees_state_t q_r;
	ees_state_t q_nxt;

	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;
	logic hit;

	// full slave address compare against the straps
	function automatic logic addr_match(input logic [7:0] cb,
		input logic [2:0] cs);
		logic t_ok;
		logic c_ok;
		t_ok = cb[`EES_CB_TYPE_MSB:`EES_CB_TYPE_LSB] == DEV_TYPE;
		c_ok = cb[`EES_CB_CS_MSB:`EES_CB_CS_LSB] == cs;
		return t_ok && c_ok;
	endfunction

	// move on one bit when sending: refill with ones so a short
	// byte can only ever release the line, never pull it
	function automatic logic [7:0] shift_out(input logic [7:0] b);
		return {b[6:0], 1'b1};
	endfunction

	// ------------------------------------------------------------------
	// bus events
	// ------------------------------------------------------------------

	// scl_q and sda_q hold the previous synced sample, so an
	// edge costs one more clock but never sees a metastable value
	// edges seen on the synchronised copies only
	assign scl_rise = pins.scl && !q_r.scl_q;
	assign scl_fall = !pins.scl && q_r.scl_q;
	// data edge with clock held high both samples
	assign start_seen = pins.scl && q_r.scl_q && q_r.sda_q
		&& !pins.sda;
	assign stop_seen = pins.scl && q_r.scl_q && !q_r.sda_q
		&& pins.sda;
	// a busy part stays silent, even for its own address
	assign hit = addr_match(q_r.shreg, pins.cs) && !q_r.busy;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------

	always_comb begin
		q_nxt = q_r;
		q_nxt.scl_q = pins.scl;
		q_nxt.sda_q = pins.sda;
		q_nxt.wr_start = 1'b0;
		q_nxt.bw.we = 1'b0;

		// internal write cycle timer
		// runs on through any new start, so a master polling with
		// control bytes keeps seeing no acknowledge until it ends
		if (q_r.busy) begin
			if (q_r.tmr == '0) begin
				q_nxt.busy = 1'b0;
			end else begin
				q_nxt.tmr = q_r.tmr - 1'b1;
			end
		end

		if (start_seen) begin
			// restart drops any byte in flight
			q_nxt.st = ST_CTRL;
			q_nxt.bitcnt = 4'h0;
			q_nxt.sda_oe = 1'b0;
		end else if (stop_seen) begin
			// protect level taken here, later changes do not matter
			// a stop after the address bytes alone writes nothing
			// and leaves the pointer where the address put it
			if (q_r.st == ST_WDATA && q_r.cnt != '0) begin
				if (pins.wp) begin
					q_nxt.blocked = 1'b1;
				end else begin
					q_nxt.blocked = 1'b0;
					q_nxt.busy = 1'b1;
					q_nxt.tmr = `EES_TMR_W'(TWC_CYC - 1);
					q_nxt.wr_start = 1'b1;
				end
			end
			q_nxt.st = ST_IDLE;
			q_nxt.bitcnt = 4'h0;
			q_nxt.sda_oe = 1'b0;
		end else if (q_r.st == ST_RDATA) begin
			if (scl_rise && q_r.bitcnt == `EES_ACK_SLOT && pins.sda) begin
				// no ack from master: let the line float for its stop
				q_nxt.st = ST_IGNORE;
				q_nxt.sda_oe = 1'b0;
			end else if (scl_fall && q_r.bitcnt == `EES_ACK_SLOT) begin
				// next byte, msb on the bus first
				q_nxt.sda_oe = !rd_data[7];
				q_nxt.shreg = shift_out(rd_data);
				q_nxt.bitcnt = 4'h1;
			end else if (scl_fall && q_r.bitcnt < `EES_BITS_PER_BYTE) begin
				// data moves only after clock has gone low
				q_nxt.sda_oe = !q_r.shreg[7];
				q_nxt.shreg = shift_out(q_r.shreg);
				q_nxt.bitcnt = q_r.bitcnt + 4'h1;
			end else if (scl_fall && q_r.bitcnt == `EES_BITS_PER_BYTE) begin
				// free the line for the master's ack
				q_nxt.sda_oe = 1'b0;
				q_nxt.addr = q_r.addr + 1'b1;
				q_nxt.bitcnt = `EES_ACK_SLOT;
			end
		end else if (q_r.st != ST_IDLE && q_r.st != ST_IGNORE) begin
			if (scl_rise && q_r.bitcnt < `EES_BITS_PER_BYTE) begin
				// one bit per pulse, sampled at the rising edge
				q_nxt.shreg = {q_r.shreg[6:0], pins.sda};
				q_nxt.bitcnt = q_r.bitcnt + 4'h1;
			end else if (scl_fall
				&& q_r.bitcnt == `EES_BITS_PER_BYTE) begin
				// pull low for the whole ninth pulse
				q_nxt.sda_oe = 1'b1;
				q_nxt.bitcnt = `EES_ACK_SLOT;
				case (q_r.st)
					ST_CTRL: begin
						if (hit) begin
							if (q_r.shreg[`EES_CB_RW] == `EES_RW_READ) begin
								q_nxt.st = ST_RDATA;
							end else begin
								q_nxt.st = ST_ADDR_HI;
							end
						end else begin
							q_nxt.st = ST_IGNORE;
							q_nxt.sda_oe = 1'b0;
						end
					end
					ST_ADDR_HI: begin
						// top address bit is dropped
						q_nxt.addr[14:8] = q_r.shreg[6:0];
						q_nxt.st = ST_ADDR_LO;
					end
					ST_ADDR_LO: begin
						q_nxt.addr[7:0] = q_r.shreg;
						q_nxt.base = {q_r.addr[14:8], q_r.shreg};
						q_nxt.cnt = '0;
						q_nxt.st = ST_WDATA;
					end
					ST_WDATA: begin
						// low pointer bits wrap inside the page
						q_nxt.bw.we = 1'b1;
						q_nxt.bw.addr = q_r.addr[`EES_PAGE_AW-1:0];
						q_nxt.bw.data = q_r.shreg;
						q_nxt.addr[`EES_PAGE_AW-1:0] =
							q_r.addr[`EES_PAGE_AW-1:0] + 1'b1;
						if (q_r.cnt < `EES_CNT_W'(`EES_PAGE_BYTES)) begin
							q_nxt.cnt = q_r.cnt + 1'b1;
						end
					end
					default: begin
						q_nxt.sda_oe = 1'b0;
					end
				endcase
			end else if (scl_fall && q_r.bitcnt == `EES_ACK_SLOT) begin
				// ack held until clock low again
				q_nxt.sda_oe = 1'b0;
				q_nxt.bitcnt = 4'h0;
			end
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------

	always_ff @(posedge clk) begin
		if (rst) begin
			q_r <= '{st: ST_IDLE, bitcnt: 4'h0, shreg: 8'hff,
				sda_oe: 1'b0, scl_q: 1'b1, sda_q: 1'b1,
				addr: `EES_ADDR_RST, base: `EES_ADDR_RST,
				cnt: '0, busy: 1'b0, tmr: '0, wr_start: 1'b0,
				blocked: 1'b0,
				bw: '{we: 1'b0, addr: '0, data: 8'h00}};
		end else begin
			q_r <= q_nxt;
		end
	end

	// ------------------------------------------------------------------
	// page buffer
	// ------------------------------------------------------------------

	// the array drains this after wr_start; a new write command may
	// overwrite it, so the drain has to end inside the busy time
	ees_page_buf u_buf (
		.clk(clk),
		.wr(q_r.bw),
		.raddr(buf_raddr),
		.rdata(buf_rdata)
	);

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe = q_r.sda_oe;
	// pointer and write descriptor straight from flip-flops, so the
	// array side never sees a decode glitch on them
	assign rd_addr = q_r.addr;
	assign wr_start = q_r.wr_start;
	assign wr_addr = q_r.base;
	assign wr_count = q_r.cnt;
	assign wr_busy = q_r.busy;
	assign wr_blocked = q_r.blocked;

endmodule

`default_nettype wire

/* ees_slave_asserts.sv */
// port assertions for the serial eeprom bus slave
`default_nettype none
`include "ees_map.svh"
module ees_sva #(
	parameter int unsigned TWC_CYC = 50
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus side
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe,
	// write side
	input wire logic wr_start,
	input wire logic [`EES_CNT_W-1:0] wr_count,
	input wire logic wr_busy,
	input wire logic wr_blocked
);
	logic [31:0] bcnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// busy length counter, cleared while idle
	always_ff @(posedge clk) begin
		if (rst || !wr_busy)
			bcnt_r <= 32'h0;
		else
			bcnt_r <= bcnt_r + 32'h1;
	end
	// a launch is a lone pulse with busy behind it
	sequence s_launch;
		wr_start ##1 (wr_busy && !wr_start);
	endsequence
	a_write_launch: assert property (wr_start |-> s_launch)
		else $error("write start without busy");
	property p_busy_len;
		$fell(wr_busy) |-> bcnt_r == TWC_CYC;
	endproperty
	property p_high_hold;
		scl_i && $past(scl_i) |-> $stable(sda_oe);
	endproperty
	property p_blocked;
		$rose(wr_blocked) |-> !wr_start && !wr_busy;
	endproperty
	property p_count;
		wr_start |-> wr_count inside {[1:64]};
	endproperty
	a_busy_length: assert property (p_busy_len)
		else $error("busy length wrong");
	a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
		else $error("sda moved with scl high");
	a_oe_high_hold: assert property (p_high_hold)
		else $error("sda unstable in high phase");
	a_busy_quiet: assert property (wr_busy |-> !sda_oe)
		else $error("driven while busy");
	a_pull_only: assert property (sda_o == 1'b0)
		else $error("sda driven high");
	a_blocked_quiet: assert property (p_blocked)
		else $error("protected write started");
	a_count_range: assert property (p_count)
		else $error("write count out of range");
endmodule
bind ees_slave ees_sva #(.TWC_CYC(TWC_CYC)) ees_sva_inst (.clk(clk), .rst(rst),
	.scl_i(scl_i), .sda_o(sda_o), .sda_oe(sda_oe), .wr_start(wr_start),
	.wr_count(wr_count), .wr_busy(wr_busy), .wr_blocked(wr_blocked));
`default_nettype wire

/* ees_sync.sv */
// two-stage synchroniser for the asynchronous pin group
`default_nettype none

module ees_sync
	import ees_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input var ees_pins_t pins_in,
	output var ees_pins_t pins_out
);

	ees_sync_t q_r;
	ees_sync_t q_nxt;

	// first stage feeds only the second stage
	always_comb begin
		q_nxt = q_r;
		q_nxt.s1 = pins_in;
		q_nxt.s2 = q_r.s1;
	end

	// idle bus levels after reset avoid a false start or stop
	always_ff @(posedge clk) begin
		if (rst) begin
			q_r <= '{s1: '{scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0},
				s2: '{scl: 1'b1, sda: 1'b1, wp: 1'b0, cs: 3'h0}};
		end else begin
			q_r <= q_nxt;
		end
	end

	assign pins_out = q_r.s2;

endmodule

`default_nettype wire

/* test_ees_slave.sv */
// self-checking bench for the serial eeprom bus slave
`default_nettype none
`include "ees_map.svh"
module test_ees_slave;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] DT = 4'h9; // type code, arbitrary
	localparam int TW = 400;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] cs = 3'h0;
	logic wp = 1'b0;
	logic [7:0] rd_data = 8'h00;
	logic [5:0] buf_raddr = 6'h00;
	wire scl, m_oe, sda_o, sda_oe, wr_start, wr_busy, wr_blocked;
	wire [`EES_ADDR_W-1:0] rd_addr, wr_addr;
	wire [`EES_CNT_W-1:0] wr_count;
	wire [7:0] buf_rdata;
	wire sda = !(m_oe || sda_oe); // pull-up
	int seed = 32'hbe5f;
	int mismatches = 0;
	int n_compared = 0;
	int nstart = 0;
	logic [7:0] bufm [64];
	bit used [64];
	function automatic logic [7:0] mem(input logic [14:0] a);
		return a[7:0] ^ {1'b0, a[14:8]};
	endfunction
	always #20 clk = ~clk;
	// array model answers the pointer a clock later
	always @(posedge clk) begin
		rd_data <= mem(rd_addr);
		if (wr_start === 1'b1)
			nstart++;
	end
	ees_bm ees_bm_inst (.clk(clk), .scl(scl), .sda_oe(m_oe), .sda(sda));
	ees_slave #(.DEV_TYPE(DT), .TWC_CYC(TW)) ees_slave_inst (.clk(clk),
		.rst(rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.chip_sel_bit0(cs[0]), .chip_sel_bit1(cs[1]), .chip_sel_bit2(cs[2]),
		.write_protect_in(wp), .rd_addr(rd_addr), .rd_data(rd_data),
		.wr_start(wr_start), .wr_addr(wr_addr), .wr_count(wr_count),
		.wr_busy(wr_busy), .wr_blocked(wr_blocked), .buf_raddr(buf_raddr),
		.buf_rdata(buf_rdata));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic report_and_stop();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic ctl(input logic [3:0] t, input logic [2:0] c,
		input logic rw, output logic k);
		ees_bm_inst.start_c();
		ees_bm_inst.tx({t, c, rw}, k);
	endtask
	// write command, then launch, buffer and busy checks
	task automatic wrcmd(input logic [15:0] a, input int n);
		logic k;
		logic [7:0] d;
		int s0;
		s0 = nstart;
		used = '{default: 0};
		ctl(DT, cs, 1'b0, k);
		chk(k, 0);
		ees_bm_inst.tx(a[15:8], k);
		chk(k, 0);
		ees_bm_inst.tx(a[7:0], k);
		chk(k, 0);
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			bufm[(a[5:0] + i) % 64] = d;
			used[(a[5:0] + i) % 64] = 1'b1;
			ees_bm_inst.tx(d, k);
			chk(k, 0);
		end
		ees_bm_inst.stop_c();
		chk(nstart - s0, !wp);
		chk(wr_blocked, wp);
		if (!wp) begin
			chk(wr_addr, a[14:0]);
			chk(wr_count, n > 64 ? 64 : n);
			for (int i = 0; i < 64; i++) if (used[i]) begin
				buf_raddr <= 6'(i);
				@(posedge clk);
				@(posedge clk);
				chk(buf_rdata, bufm[i]);
			end
		end
		ctl(DT, cs, 1'b0, k);
		chk(k, !wp);
		ees_bm_inst.stop_c();
		for (int i = 0; i < 600 && wr_busy; i++) @(posedge clk);
		chk(wr_busy, 0);
	endtask
	initial begin
		logic k;
		logic [7:0] d;
		logic [15:0] a;
		repeat (8) @(posedge clk);
		cs <= 3'($random(seed));
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		wrcmd(16'($random(seed)), 1);
		wrcmd(16'($random(seed)), 66);
		$display("write test done");
		for (int c = 0; c < 8; c++) begin
			ctl(DT, 3'(c), 1'b0, k);
			chk(k, 3'(c) != cs);
			ees_bm_inst.stop_c();
		end
		ctl(~DT, cs, 1'b0, k);
		chk(k, 1);
		ees_bm_inst.stop_c();
		$display("select test done");
		a = 16'($random(seed));
		ctl(DT, cs, 1'b0, k);
		ees_bm_inst.tx(a[15:8], k);
		ees_bm_inst.tx(a[7:0], k);
		ctl(DT, cs, 1'b1, k);
		chk(k, 0);
		ees_bm_inst.rx(1'b0, d);
		chk(d, mem(a[14:0]));
		ees_bm_inst.rx(1'b1, d);
		chk(d, mem(a[14:0] + 15'h1));
		ees_bm_inst.stop_c();
		chk(nstart, 2);
		$display("read test done");
		ees_bm_inst.start_c();
		for (int i = 0; i < 4; i++) ees_bm_inst.bit_x(1'b0, k);
		ctl(DT, cs, 1'b0, k);
		chk(k, 0);
		ees_bm_inst.stop_c();
		$display("abort test done");
		wp <= 1'b1;
		wrcmd(16'($random(seed)), 2);
		wp <= 1'b0;
		$display("protect test done");
		report_and_stop();
	end
	// hang guard, about 50000 clocks
	initial begin
		#2000000;
		mismatches++;
		report_and_stop();
	end
endmodule
`default_nettype wire
